// ### bench/fnsc_nv_model.sv
// non-volatile configuration memory model beside the loader
`timescale 1ns/1ps
`default_nettype none
module fnsc_nv_model (
    input wire logic sys_clk,
    input wire logic nv_write,
    input wire logic [31:0] nv_write_data,
    output logic [31:0] nv_stored_config
);
    // no reset: contents survive power cycles
    initial nv_stored_config = 32'h0000_0000;
    always @(posedge sys_clk) begin
        if (nv_write === 1'b1) begin
            nv_stored_config <= nv_write_data;
        end
    end
endmodule : fnsc_nv_model
`default_nettype wire

// ### bench/fnsc_top_properties.sv
// port checker for the switch configuration loader
`timescale 1ns/1ps
`default_nettype none
module fnsc_top_properties #(
    parameter logic [26:0] BLINK_CYCLES = 27'h8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [31:0] present_config,
    input wire logic bus_comm_error,
    input wire logic bus_idle,
    input wire logic control_supply_bad,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] output_size_bytes,
    input wire logic [1:0] link_rate_sel,
    input wire logic [3:0] diag_append_bytes,
    input wire logic [6:0] diag_unit_limit,
    input wire logic diag_mode_reserved,
    input wire logic outputs_clear,
    input wire logic nv_write,
    input wire logic [31:0] nv_write_data,
    input wire logic config_mismatch,
    input wire logic unit_diagnostic_indicator_red,
    input wire logic unit_diagnostic_indicator_green,
    input wire logic control_supply_indicator_red,
    input wire logic control_supply_indicator_green
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // internal reset lags rst_b, so decoded outputs need a few edges
    logic [2:0] up_reg;
    logic up_ok;
    logic rd_done;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_reg <= 3'h0;
        end else if (up_reg != 3'h7) begin
            up_reg <= up_reg + 3'h1;
        end
    end
    assign up_ok = (up_reg >= 3'h5);
    assign rd_done = avs_read && !avs_waitrequest;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_done;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    a_bus_handshake: assert property (
        ($rose(avs_read) || $rose(avs_write)) |-> s_req_wait ##1 s_req_done
    ) else $error("bus request not answered after one wait cycle");
    a_unmapped_zero: assert property (
        rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0
    ) else $error("unmapped read not zero");
    a_config_live: assert property (
        rd_done && avs_address == 4'hC |->
        avs_readdata == $past(present_config)
    ) else $error("configuration word read wrong");
    a_size_decode: assert property (
        rd_done && avs_address == 4'h0 && up_ok |->
        output_size_bytes == 3'h4 - {1'b0, avs_readdata[20:19]}
    ) else $error("output size decode wrong");
    a_link_decode: assert property (
        rd_done && avs_address == 4'h0 && up_ok |->
        link_rate_sel == avs_readdata[18:17]
    ) else $error("link rate decode wrong");
    a_diag_bytes: assert property (
        rd_done && avs_address == 4'h0 && up_ok |-> diag_append_bytes ==
        (avs_readdata[16] ? (avs_readdata[15] ? 4'hC : 4'h6) :
        (avs_readdata[15] ? 4'h4 : 4'h0))
    ) else $error("diagnostic byte count wrong");
    a_reserved_mode: assert property (
        diag_mode_reserved |-> diag_append_bytes == 4'hC &&
        diag_unit_limit == 7'h40
    ) else $error("reserved mode sizes wrong");
    a_clear_quiet: assert property (
        up_ok && !$past(bus_comm_error) && !$past(bus_idle) |-> !outputs_clear
    ) else $error("outputs cleared without bus fault");
    a_store_pulse: assert property (
        nv_write |-> nv_write_data == $past(present_config) ##1 !nv_write
    ) else $error("store pulse wrong");
    a_mismatch_stuck: assert property (
        config_mismatch |=> config_mismatch
    ) else $error("mismatch flag dropped");
    a_supply_led: assert property (
        up_ok |-> control_supply_indicator_red == $past(control_supply_bad)
        && control_supply_indicator_green == !$past(control_supply_bad)
    ) else $error("control supply indicator wrong");
    a_unit_apart: assert property (
        !(unit_diagnostic_indicator_red && unit_diagnostic_indicator_green)
    ) else $error("unit indicator red and green together");
endmodule : fnsc_top_properties
bind fnsc_top fnsc_top_properties #(.BLINK_CYCLES(BLINK_CYCLES))
    fnsc_top_properties_inst (.*);
`default_nettype wire

// ### bench/fnsc_top_tb_top.sv
// self-checking bench for the switch configuration loader
`timescale 1ns/1ps
`default_nettype none
module fnsc_top_tb_top;
    localparam int BLINK = 8;
    logic sys_clk = 1'b0, rst_b = 1'b0;
    logic [3:0] setting1_sw = 4'h0, address_sw_tens = 4'h0;
    logic [4:0] setting2_sw = 5'h00;
    logic [3:0] address_sw_ones = 4'h0, rate_sw = 4'h0, avs_address = 4'h0;
    logic [31:0] present_config = 32'h0, avs_writedata = 32'h0;
    logic bus_comm_error = 1'b0, bus_idle = 1'b0, component_failure = 1'b0;
    logic valve_short_open = 1'b0, valve_count_exceeded = 1'b0;
    logic detect_enable = 1'b0, unit_link_fail = 1'b0;
    logic other_unit_error = 1'b0, control_supply_bad = 1'b0;
    logic output_supply_bad = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_readdata, nv_write_data, nv_stored_config, rd;
    logic avs_waitrequest, diag_mode_reserved, outputs_clear, nv_write;
    logic [2:0] output_size_bytes;
    logic [1:0] link_rate_sel, bus_rate_sel;
    logic [3:0] diag_append_bytes;
    logic [6:0] diag_unit_limit;
    logic [5:0] node_address;
    logic config_mismatch, unit_diagnostic_indicator_red;
    logic unit_diagnostic_indicator_green, control_supply_indicator_red;
    logic control_supply_indicator_green, output_supply_indicator_red;
    logic output_supply_indicator_green;
    int n_fail = 0, comparisons = 0, r_n, g_n;
    int dbytes[4] = '{0, 4, 6, 12};
    int dunits[4] = '{0, 0, 10, 64};
    int er[5] = '{2 * BLINK, 2 * BLINK, 0, 0, 4 * BLINK};
    int eg[5] = '{2 * BLINK, 0, 4 * BLINK, 2 * BLINK, 0};

    fnsc_top #(.BLINK_CYCLES(27'(BLINK))) fnsc_top_inst (.*);
    fnsc_nv_model fnsc_nv_model_inst (.sys_clk(sys_clk), .nv_write(nv_write),
        .nv_write_data(nv_write_data), .nv_stored_config(nv_stored_config));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        check("bus waits", 32'd2, n);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // a power cycle: switches only matter while the unit comes up
    task automatic power_up(input logic [3:0] s1, input logic [4:0] s2,
                            input logic [3:0] t, o, r);
        rst_b <= 1'b0;
        setting1_sw <= s1;
        setting2_sw <= s2;
        address_sw_tens <= t;
        address_sw_ones <= o;
        rate_sw <= r;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask : power_up

    task automatic fault(input logic e, input logic i, input logic exp);
        bus_comm_error <= e;
        bus_idle <= i;
        repeat (3) @(posedge sys_clk);
        check("outputs_clear", exp, outputs_clear);
    endtask : fault

    task automatic blink();
        r_n = 0;
        g_n = 0;
        repeat (3) @(posedge sys_clk);
        repeat (4 * BLINK) begin
            @(posedge sys_clk);
            r_n += (unit_diagnostic_indicator_red === 1'b1);
            g_n += (unit_diagnostic_indicator_green === 1'b1);
        end
    endtask : blink

    task automatic final_report();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end

    initial begin
        for (int i = 0; i < 4; i++) begin
            power_up(4'(i * 5), 5'(i * 8), 4'h0, 4'(i), 4'(i));
            check("size", 4 - i, output_size_bytes);
            check("link", i, link_rate_sel);
            check("diag", dbytes[i], diag_append_bytes);
            check("units", dunits[i], diag_unit_limit);
            check("resv", i == 3, diag_mode_reserved);
            check("node", i, node_address);
            if (i < 3) check("rate", i, bus_rate_sel);
        end
        setting1_sw <= 4'h0;
        setting2_sw <= 5'h00;
        repeat (4) @(posedge sys_clk);
        check("held", 32'h1, output_size_bytes);
        bus(1'b0, 4'h0, 32'h0, rd);
        check("swreg", 32'h001F_8033, rd);
        $display("test decode done");
        power_up(4'h0, 5'h00, 4'h4, 4'h2, 4'h1);
        bus(1'b0, 4'h4, 32'h0, rd);
        check("netrst", 32'h0, rd);
        bus(1'b1, 4'h4, 32'h0000_0205, rd);
        repeat (2) @(posedge sys_clk);
        check("swwin", 32'd42, node_address);
        power_up(4'h0, 5'h02, 4'h9, 4'h9, 4'h5);
        bus(1'b1, 4'h4, 32'h0000_0205, rd);
        repeat (2) @(posedge sys_clk);
        check("netaddr", 32'h5, node_address);
        check("netrate", 32'h2, bus_rate_sel);
        bus(1'b0, 4'h2, 32'h0, rd);
        check("unmap", 32'h0, rd);
        power_up(4'h0, 5'h00, 4'h9, 4'h9, 4'h5);
        bus(1'b1, 4'h4, 32'h0000_0205, rd);
        repeat (2) @(posedge sys_clk);
        check("pgmaddr", 32'h5, node_address);
        check("pgmrate", 32'h2, bus_rate_sel);
        $display("test address done");
        power_up(4'h0, 5'h00, 4'h0, 4'h0, 4'h0);
        fault(1'b1, 1'b0, 1'b1);
        fault(1'b0, 1'b1, 1'b1);
        fault(1'b0, 1'b0, 1'b0);
        bus(1'b1, 4'h4, 32'h0003_0000, rd);
        fault(1'b1, 1'b0, 1'b0);
        power_up(4'h0, 5'h04, 4'h0, 4'h0, 4'h0);
        fault(1'b1, 1'b0, 1'b0);
        bus(1'b1, 4'h4, 32'h0001_0000, rd);
        fault(1'b1, 1'b0, 1'b1);
        fault(1'b0, 1'b0, 1'b0);
        $display("test hold done");
        present_config <= 32'hA5C3_0F12;
        power_up(4'h0, 5'h01, 4'h0, 4'h0, 4'h0);
        check("stored", 32'hA5C3_0F12, nv_stored_config);
        power_up(4'h0, 5'h00, 4'h0, 4'h0, 4'h0);
        check("match", 32'h0, config_mismatch);
        present_config <= 32'hA5C3_0F13;
        power_up(4'h0, 5'h00, 4'h0, 4'h0, 4'h0);
        check("mism", 32'h1, config_mismatch);
        bus(1'b0, 4'h8, 32'h0, rd);
        check("status", 32'h1, rd[0]);
        bus(1'b0, 4'hC, 32'h0, rd);
        check("cfgreg", 32'hA5C3_0F13, rd);
        blink();
        check("mred", 2 * BLINK, r_n);
        check("mgreen", 2 * BLINK, g_n);
        $display("test memory done");
        present_config <= 32'hA5C3_0F12;
        power_up(4'h0, 5'h00, 4'h0, 4'h0, 4'h0);
        control_supply_bad <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("csup", 32'h1, control_supply_indicator_red);
        check("osup", 32'h1, output_supply_indicator_green);
        output_supply_bad <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("osupbad", 32'h1, output_supply_indicator_red);
        for (int k = 0; k < 5; k++) begin
            unit_link_fail <= (k == 0);
            valve_short_open <= (k == 1);
            valve_count_exceeded <= (k == 2);
            detect_enable <= (k != 2);
            other_unit_error <= (k == 3);
            component_failure <= (k == 4);
            blink();
            check("ured", er[k], r_n);
            check("ugreen", eg[k], g_n);
        end
        $display("test indicators done");
        final_report();
    end
endmodule : fnsc_top_tb_top
`default_nettype wire

// ### rtl/fnsc_defines.svh
// constants for the fieldbus node switch configuration loader
`ifndef FNSC_DEFINES_SVH
`define FNSC_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FNSC_OFS_SETTINGS 4'h0
`define FNSC_OFS_NET_CTRL 4'h4
`define FNSC_OFS_STATUS 4'h8
`define FNSC_OFS_CONFIG 4'hC

// ----------------------------------------
// network control register fields and reset
// ----------------------------------------
`define FNSC_NET_ADDR_LSB 0
`define FNSC_NET_RATE_LSB 8
`define FNSC_NET_OVR_BIT 16
`define FNSC_NET_HOLD_BIT 17
`define FNSC_NET_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// switch decoding values
// ----------------------------------------
`define FNSC_MAX_NODE_ADDR 7'h3F
`define FNSC_MAX_DIGIT 4'h9
`define FNSC_RATE_SW_LAST 4'h2
`define FNSC_DIAG_BYTES_M1 4'h4
`define FNSC_DIAG_BYTES_M2 4'h6
`define FNSC_DIAG_BYTES_M3 4'hC
`define FNSC_DIAG_UNITS_M2 7'h0A
`define FNSC_DIAG_UNITS_M3 7'h40

// ----------------------------------------
// timing
// ----------------------------------------
`define FNSC_CLK_KHZ 100000
`define FNSC_BLINK_TIME_MS 1000
`define FNSC_BLINK_CYCLES (`FNSC_BLINK_TIME_MS * `FNSC_CLK_KHZ)

`endif

// ### rtl/fnsc_pkg.sv
// types for the fieldbus node switch configuration loader
package fnsc_pkg;

    typedef enum logic [2:0] {
        FNSC_ST_CAPTURE = 3'b001,
        FNSC_ST_CONFIG = 3'b010,
        FNSC_ST_RUN = 3'b100
    } fnsc_state_type;

    typedef enum logic [1:0] {
        FNSC_LINK_1M = 2'h0,
        FNSC_LINK_500K = 2'h1,
        FNSC_LINK_250K = 2'h2,
        FNSC_LINK_125K = 2'h3
    } fnsc_link_rate_type;

    typedef enum logic [1:0] {
        FNSC_BUS_125K = 2'h0,
        FNSC_BUS_250K = 2'h1,
        FNSC_BUS_500K = 2'h2
    } fnsc_bus_rate_type;

endpackage : fnsc_pkg

// ### rtl/fnsc_top.sv
// power-up switch sampling, decode, config compare and indicators
//
// Overview of operation
// - switches sampled once at power-up; later changes ignored
// - output size pair: OFF/OFF 32, OFF/ON 24, ON/OFF 16, ON/ON 8 bits
// - bits three and four pick link rate 1M, 500k, 250k, 125k
// - diagnostic mode appends 0, 4, 6 or 12 status bytes to input data
// - mode 2 covers ten units; mode 3 sixty-four units, reserved
// - fault action OFF clears outputs on bus error or idle; ON holds
// - network-set parameter overrides the fault action switch
// - address source OFF: address and rate come from the switches
// - address source ON: address and rate come from the bus master
// - memory switch ON at power-up stores present configuration
// - memory switch OFF at power-up compares and flags any mismatch
// - unit indicator shows valve short/open or count over limit when enabled
// - unit indicator distinct for link or memory fault, another for remote
// - separate indicators for control supply and output supply faults
// - alternating red and green pattern toggles at one second
// - rate switch 0 125k, 1 250k, 2 500k, 3 to 9 network
// - network position switch takes speed from the network value
`timescale 1ns/1ps
`default_nettype none
`include "fnsc_defines.svh"

module fnsc_top #(
    parameter logic [26:0] BLINK_CYCLES = 27'(`FNSC_BLINK_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] setting1_sw,
    input wire logic [4:0] setting2_sw,
    input wire logic [3:0] address_sw_tens,
    input wire logic [3:0] address_sw_ones,
    input wire logic [3:0] rate_sw,
    input wire logic [31:0] present_config,
    input wire logic [31:0] nv_stored_config,
    input wire logic bus_comm_error,
    input wire logic bus_idle,
    input wire logic component_failure,
    input wire logic valve_short_open,
    input wire logic valve_count_exceeded,
    input wire logic detect_enable,
    input wire logic unit_link_fail,
    input wire logic other_unit_error,
    input wire logic control_supply_bad,
    input wire logic output_supply_bad,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [2:0] output_size_bytes,
    output logic [1:0] link_rate_sel,
    output logic [3:0] diag_append_bytes,
    output logic [6:0] diag_unit_limit,
    output logic diag_mode_reserved,
    output logic outputs_clear,
    output logic [5:0] node_address,
    output logic [1:0] bus_rate_sel,
    output logic nv_write,
    output logic [31:0] nv_write_data,
    output logic config_mismatch,
    output logic unit_diagnostic_indicator_red,
    output logic unit_diagnostic_indicator_green,
    output logic control_supply_indicator_red,
    output logic control_supply_indicator_green,
    output logic output_supply_indicator_red,
    output logic output_supply_indicator_green
);

    // ----------------------------------------
    // reset release and switch synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // no reset here: the chains fill while reset is still held,
    // so the first capture already sees settled switch levels
    localparam int SW_W = 21;
    logic [SW_W-1:0] sw_meta_reg;
    logic [SW_W-1:0] sw_sync_reg;

    always_ff @(posedge sys_clk) begin
        sw_meta_reg <= {setting1_sw, setting2_sw, address_sw_tens,
                        address_sw_ones, rate_sw};
        sw_sync_reg <= sw_meta_reg;
    end

    // ----------------------------------------
    // power-up capture and config sequence
    // ----------------------------------------
    fnsc_pkg::fnsc_state_type state_reg, state_next;
    logic [SW_W-1:0] sw_hold_reg, sw_hold_next;
    logic nv_write_reg, nv_write_next;
    logic [31:0] nv_data_reg, nv_data_next;
    logic mismatch_reg, mismatch_next;
    logic stored_reg, stored_next;

    always_comb begin
        state_next = state_reg;
        sw_hold_next = sw_hold_reg;
        nv_write_next = 1'b0;
        nv_data_next = nv_data_reg;
        mismatch_next = mismatch_reg;
        stored_next = stored_reg;
        unique case (state_reg)
            fnsc_pkg::FNSC_ST_CAPTURE: begin
                sw_hold_next = sw_sync_reg;
                state_next = fnsc_pkg::FNSC_ST_CONFIG;
            end
            fnsc_pkg::FNSC_ST_CONFIG: begin
                if (sw_hold_reg[12]) begin
                    nv_write_next = 1'b1;
                    nv_data_next = present_config;
                    stored_next = 1'b1;
                end else begin
                    mismatch_next = present_config
                                    != nv_stored_config;
                end
                state_next = fnsc_pkg::FNSC_ST_RUN;
            end
            fnsc_pkg::FNSC_ST_RUN: begin
                state_next = fnsc_pkg::FNSC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fnsc_pkg::FNSC_ST_CAPTURE;
            sw_hold_reg <= '0;
            nv_write_reg <= 1'b0;
            nv_data_reg <= 32'h0000_0000;
            mismatch_reg <= 1'b0;
            stored_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sw_hold_reg <= sw_hold_next;
            nv_write_reg <= nv_write_next;
            nv_data_reg <= nv_data_next;
            mismatch_reg <= mismatch_next;
            stored_reg <= stored_next;
        end
    end

    // held switch fields
    logic [1:0] vsel;
    logic [1:0] lrate;
    logic [1:0] dmode;
    logic sw_hold_out;
    logic address_source_select;
    logic [3:0] tens;
    logic [3:0] ones;
    logic [3:0] rsw;
    assign vsel = sw_hold_reg[20:19];
    assign lrate = sw_hold_reg[18:17];
    assign dmode = sw_hold_reg[16:15];
    assign sw_hold_out = sw_hold_reg[14];
    assign address_source_select = sw_hold_reg[13];
    assign tens = sw_hold_reg[11:8];
    assign ones = sw_hold_reg[7:4];
    assign rsw = sw_hold_reg[3:0];

    // ----------------------------------------
    // avalon slave, one wait cycle per access
    // ----------------------------------------
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] net_ctrl_reg, net_ctrl_next;
    logic [31:0] settings_word;
    logic [31:0] status_word;

    assign settings_word = {11'h000, sw_hold_reg};
    assign status_word = {22'h00_0000, output_supply_bad,
                          control_supply_bad, other_unit_error,
                          unit_link_fail, valve_count_exceeded,
                          valve_short_open, component_failure,
                          state_reg == fnsc_pkg::FNSC_ST_RUN,
                          stored_reg, mismatch_reg};

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;

    always_comb begin
        ack_next = (avs_read | avs_write) & ~ack_reg;
        rdata_next = rdata_reg;
        net_ctrl_next = net_ctrl_reg;
        if (avs_read && !ack_reg) begin
            unique case (avs_address)
                `FNSC_OFS_SETTINGS: rdata_next = settings_word;
                `FNSC_OFS_NET_CTRL: rdata_next = net_ctrl_reg;
                `FNSC_OFS_STATUS: rdata_next = status_word;
                `FNSC_OFS_CONFIG: rdata_next = present_config;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (avs_write && ack_reg && avs_address == `FNSC_OFS_NET_CTRL) begin
            net_ctrl_next = avs_writedata & 32'h0003_033F;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            net_ctrl_reg <= `FNSC_NET_CTRL_RESET;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            net_ctrl_reg <= net_ctrl_next;
        end
    end

    // ----------------------------------------
    // setting decode
    // ----------------------------------------
    logic [6:0] sw_addr;
    logic sw_addr_ok;
    logic rate_sw_ok;

    assign sw_addr = {tens, 3'h0} + {2'h0, tens, 1'b0}
                     + {3'h0, ones};
    // a non-decimal digit or a value past 63 means the network position
    assign sw_addr_ok = tens <= `FNSC_MAX_DIGIT && ones <= `FNSC_MAX_DIGIT
                        && sw_addr <= `FNSC_MAX_NODE_ADDR;
    assign rate_sw_ok = rsw <= `FNSC_RATE_SW_LAST;

    logic [2:0] size_next;
    logic [3:0] diag_next;
    logic [6:0] units_next;
    logic [5:0] addr_next;
    logic [1:0] brate_next;
    logic hold_eff;
    logic clear_next;

    always_comb begin
        unique case (vsel)
            2'h0: size_next = 3'h4;
            2'h1: size_next = 3'h3;
            2'h2: size_next = 3'h2;
            default: size_next = 3'h1;
        endcase
        unique case (dmode)
            2'h0: diag_next = 4'h0;
            2'h1: diag_next = `FNSC_DIAG_BYTES_M1;
            2'h2: diag_next = `FNSC_DIAG_BYTES_M2;
            default: diag_next = `FNSC_DIAG_BYTES_M3;
        endcase
        unique case (dmode)
            2'h2: units_next = `FNSC_DIAG_UNITS_M2;
            2'h3: units_next = `FNSC_DIAG_UNITS_M3;
            default: units_next = 7'h00;
        endcase
        if (!address_source_select && sw_addr_ok) begin
            addr_next = sw_addr[5:0];
        end else begin
            addr_next = net_ctrl_reg[5:0];
        end
        if (!address_source_select && rate_sw_ok) begin
            brate_next = rsw[1:0];
        end else begin
            brate_next = net_ctrl_reg[9:8];
        end
        hold_eff = net_ctrl_reg[`FNSC_NET_OVR_BIT] ?
                   net_ctrl_reg[`FNSC_NET_HOLD_BIT] : sw_hold_out;
        clear_next = (bus_comm_error | bus_idle) & ~hold_eff;
    end

    logic [2:0] size_reg;
    logic [3:0] diag_reg;
    logic [6:0] units_reg;
    logic reserved_reg;
    logic [5:0] addr_reg;
    logic [1:0] brate_reg;
    logic [1:0] lrate_reg;
    logic clear_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            size_reg <= 3'h4;
            diag_reg <= 4'h0;
            units_reg <= 7'h00;
            reserved_reg <= 1'b0;
            addr_reg <= 6'h00;
            brate_reg <= 2'h0;
            lrate_reg <= 2'h0;
            clear_reg <= 1'b1;
        end else begin
            size_reg <= size_next;
            diag_reg <= diag_next;
            units_reg <= units_next;
            reserved_reg <= dmode == 2'h3;
            addr_reg <= addr_next;
            brate_reg <= brate_next;
            lrate_reg <= lrate;
            clear_reg <= clear_next;
        end
    end

    assign output_size_bytes = size_reg;
    assign link_rate_sel = lrate_reg;
    assign diag_append_bytes = diag_reg;
    assign diag_unit_limit = units_reg;
    assign diag_mode_reserved = reserved_reg;
    assign node_address = addr_reg;
    assign bus_rate_sel = brate_reg;
    assign outputs_clear = clear_reg;
    assign nv_write = nv_write_reg;
    assign nv_write_data = nv_data_reg;
    assign config_mismatch = mismatch_reg;

    // ----------------------------------------
    // indicators
    // ----------------------------------------
    logic [26:0] blink_cnt_reg, blink_cnt_next;
    logic blink_reg, blink_next;
    logic [5:0] led_reg, led_next;

    always_comb begin
        blink_cnt_next = blink_cnt_reg + 27'h1;
        blink_next = blink_reg;
        if (blink_cnt_reg >= BLINK_CYCLES - 27'h1) begin
            blink_cnt_next = 27'h0;
            blink_next = ~blink_reg;
        end
        // priority: internal failure, valve, link/memory, remote unit
        if (component_failure) begin
            led_next[1:0] = 2'b10;
        end else if (detect_enable &&
                     (valve_short_open || valve_count_exceeded)) begin
            led_next[1:0] = {blink_reg, 1'b0};
        end else if (unit_link_fail || mismatch_reg) begin
            led_next[1:0] = {blink_reg, ~blink_reg};
        end else if (other_unit_error) begin
            led_next[1:0] = {1'b0, blink_reg};
        end else begin
            led_next[1:0] = 2'b01;
        end
        led_next[3:2] = control_supply_bad ? 2'b10 : 2'b01;
        led_next[5:4] = output_supply_bad ? 2'b10 : 2'b01;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_reg <= 27'h0;
            blink_reg <= 1'b0;
            led_reg <= 6'h00;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            led_reg <= led_next;
        end
    end

    assign unit_diagnostic_indicator_red = led_reg[1];
    assign unit_diagnostic_indicator_green = led_reg[0];
    assign control_supply_indicator_red = led_reg[3];
    assign control_supply_indicator_green = led_reg[2];
    assign output_supply_indicator_red = led_reg[5];
    assign output_supply_indicator_green = led_reg[4];

endmodule : fnsc_top
`default_nettype wire
